/* File: rtl/pdh_consts.vh */
// constants for the packet descriptor handler: descriptor layout,
// command/status fields, bus register map and bit positions.
// assumes inclusion by bare name from the design file.
//
// Functional notes
// - descriptor word 0 links next, bits 1:0 zero
// - device reads cmdsts at 4, writes completion back
// - default buffer pointer at 8, tx any byte
// - each descriptor is exactly one fragment
// - legacy layout: pointer at 12, 8 ignored
// - bit 31 ownership, producer sets, consumer clears
// - tx host produces, rx device produces
// - bit 30 set means more descriptors follow
// - bit 29 requests interrupt at ownership return
// - tx bit 28 suppresses fcs append
// - rx always sets bit 28, fcs included
// - bit 27 marks good packet in last
// - bits 26:16 status decoded by direction
// - bits 11:0 hold buffer byte count
`ifndef PDH_CONSTS_VH
`define PDH_CONSTS_VH

// descriptor word offsets
`define PDH_OFF_LINK    32'h0000_0000
`define PDH_OFF_CMD     32'h0000_0004
`define PDH_OFF_BUF     32'h0000_0008
`define PDH_OFF_BUF_LEG 32'h0000_000C

// command/status field positions
`define PDH_BIT_OWN  31
`define PDH_BIT_MORE 30
`define PDH_BIT_DESCRIPTOR_INTERRUPT_REQUEST 29
`define PDH_BIT_FCS  28
`define PDH_BIT_OK   27
`define PDH_ST_HI    26
`define PDH_ST_LO    16
`define PDH_RSV_HI   15
`define PDH_RSV_LO   12
`define PDH_SZ_HI    11
`define PDH_SZ_LO    0

// register byte offsets (low address bits)
`define PDH_REG_CTRL  8'h00
`define PDH_REG_DESC  8'h04
`define PDH_REG_STAT  8'h08
`define PDH_REG_IEN   8'h0C
`define PDH_REG_ICLR  8'h10
`define PDH_REG_STATE 8'h14

// control bits
`define PDH_CTL_EN   0
`define PDH_CTL_RX   1
`define PDH_CTL_LEG  2
`define PDH_CTL_POLL 3

// event bits and width
`define PDH_EV_DINT  0
`define PDH_EV_STALL 1
`define PDH_EV_PKT   2
`define PDH_EV_W     3

`endif

/* File: rtl/pdh_descriptor_handler.v */
// descriptor engine of a bus-mastering network controller: walks a
// linked list of descriptors in host memory, hands fragments to the mac
// and writes completion back; registers over ahb-lite.
// assumes one clock for bus slave, memory master and mac side; the
// memory port holds each request until a one-cycle acknowledge.
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pdh_consts.vh"

module pdh_descriptor_handler #(
  parameter SW = 11, // direction-specific status width
  parameter CW = 12  // byte count width
) (
  input  wire          ref_clk_in,
  input  wire          reset_n_in,
  // ahb-lite slave
  input  wire          hsel_in,
  input  wire [31:0]   haddr_in,
  input  wire [1:0]    htrans_in,
  input  wire          hwrite_in,
  input  wire [2:0]    hsize_in,
  input  wire [31:0]   hwdata_in,
  input  wire          hready_in,
  output wire [31:0]   hrdata_out,
  output wire          hreadyout_out,
  output wire          hresp_out,
  // host memory master
  output wire          mem_req_out,
  output wire          mem_write_out,
  output wire [31:0]   mem_addr_out,
  output wire [31:0]   mem_wdata_out,
  input  wire          mem_ack_in,
  input  wire [31:0]   mem_rdata_in,
  // fragment hand-off to the mac
  output wire          frag_valid_out,
  output wire [31:0]   frag_addr_out,
  output wire [CW-1:0] frag_size_out,
  output wire          frag_last_out,
  output wire          frag_rx_out,
  output wire          suppress_fcs_append_out,
  input  wire          frag_done_in,
  input  wire [CW-1:0] frag_size_in,
  input  wire          frag_last_in,
  input  wire          frag_ok_in,
  input  wire [SW-1:0] frag_status_in,
  // interrupt
  output wire          irq_out
);

  // one-hot engine states
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_LINK = 8'h02;
  localparam [7:0] S_CMD  = 8'h04;
  localparam [7:0] S_BUF  = 8'h08;
  localparam [7:0] S_XFER = 8'h10;
  localparam [7:0] S_WB   = 8'h20;

  reg  [7:0]          state_ff;      // engine state
  reg  [7:0]          nxt_state;     // next engine state
  reg  [31:0]         cur_ff;        // current descriptor address
  reg  [31:0]         link_ff;       // fetched link word
  reg  [31:0]         cmd_ff;        // fetched command/status word
  reg  [31:0]         buf_ff;        // fetched buffer pointer
  reg  [31:0]         wb_ff;         // completion word to write back
  reg                 req_ff;        // memory request pending
  reg                 mwr_ff;        // memory request is a write
  reg  [31:0]         maddr_ff;      // memory address
  reg                 fv_ff;         // fragment offered to mac
  reg  [3:0]          ctrl_ff;       // enable, rx, legacy; bit 3 held zero
  reg                 poll_ff;       // refetch requested by software
  reg  [`PDH_EV_W-1:0] stat_ff;      // sticky events
  reg  [`PDH_EV_W-1:0] ien_ff;       // interrupt enables
  reg                 dp_ff;         // bus data phase pending
  reg                 dpw_ff;        // data phase is a write
  reg  [7:0]          dpa_ff;        // data phase register offset
  reg  [31:0]         rdata_ff;      // read data for data phase

  wire en   = ctrl_ff[`PDH_CTL_EN];
  wire rx   = ctrl_ff[`PDH_CTL_RX];
  wire leg  = ctrl_ff[`PDH_CTL_LEG];
  wire own  = cmd_ff[`PDH_BIT_OWN];
  wire more = cmd_ff[`PDH_BIT_MORE];
  wire descriptor_interrupt_request = cmd_ff[`PDH_BIT_DESCRIPTOR_INTERRUPT_REQUEST];

  // tx: device consumes, usable while own set; rx: device produces,
  // usable while own clear
  wire usable = rx ? ~own : own;

  // legacy layout moves the pointer and skips the count word
  wire [31:0] buf_off = leg ? `PDH_OFF_BUF_LEG : `PDH_OFF_BUF;

  // a fragment is last by its descriptor on tx, by the mac on rx
  wire last = rx ? frag_last_in : ~more;

  // ahb address phase acceptance
  wire acc = hsel_in & htrans_in[1] & hready_in;
  wire wr  = dp_ff & dpw_ff;

  // events raised this cycle by the engine
  reg [`PDH_EV_W-1:0] ev;

  // next-state and event decode
  always @* begin
    nxt_state = state_ff;
    ev        = {`PDH_EV_W{1'b0}};
    case (state_ff)
      S_IDLE: begin
        // only a poll starts a fetch, so a stalled list waits here
        if (en && poll_ff) begin
          nxt_state = S_LINK;
        end
      end
      S_LINK: begin
        if (mem_ack_in) begin
          nxt_state = S_CMD;
        end
      end
      S_CMD: begin
        if (mem_ack_in) begin
          if (rx ? ~mem_rdata_in[`PDH_BIT_OWN]
                 : mem_rdata_in[`PDH_BIT_OWN]) begin
            nxt_state = S_BUF;
          end else begin
            // producer still holds it: stop, no write-back
            nxt_state            = S_IDLE;
            ev[`PDH_EV_STALL]    = 1'b1;
          end
        end
      end
      S_BUF: begin
        if (mem_ack_in) begin
          nxt_state = S_XFER;
        end
      end
      S_XFER: begin
        if (frag_done_in) begin
          nxt_state = S_WB;
        end
      end
      S_WB: begin
        if (mem_ack_in) begin
          // ownership returns now, so the interrupt fires now
          ev[`PDH_EV_DINT] = descriptor_interrupt_request;
          ev[`PDH_EV_PKT]  = ~wb_ff[`PDH_BIT_MORE];
          nxt_state        = en ? S_LINK : S_IDLE;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  // engine datapath and memory master
  always @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      state_ff <= S_IDLE;
      cur_ff   <= 32'h0000_0000;
      link_ff  <= 32'h0000_0000;
      cmd_ff   <= 32'h0000_0000;
      buf_ff   <= 32'h0000_0000;
      wb_ff    <= 32'h0000_0000;
      req_ff   <= 1'b0;
      mwr_ff   <= 1'b0;
      maddr_ff <= 32'h0000_0000;
      fv_ff    <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      // request drops on the acknowledge, reissued below if needed
      if (mem_ack_in) begin
        req_ff <= 1'b0;
      end
      case (state_ff)
        S_IDLE: begin
          // software may reposition the list only while idle
          if (wr && dpa_ff == `PDH_REG_DESC) begin
            cur_ff <= {hwdata_in[31:2], 2'b00};
          end
          if (en && poll_ff) begin
            req_ff   <= 1'b1;
            mwr_ff   <= 1'b0;
            maddr_ff <= cur_ff + `PDH_OFF_LINK;
          end
        end
        S_LINK: begin
          if (mem_ack_in) begin
            // low two bits forced clear, descriptors are word aligned
            link_ff  <= {mem_rdata_in[31:2], 2'b00};
            req_ff   <= 1'b1;
            maddr_ff <= cur_ff + `PDH_OFF_CMD;
          end
        end
        S_CMD: begin
          if (mem_ack_in) begin
            cmd_ff <= mem_rdata_in;
            if (rx ? ~mem_rdata_in[`PDH_BIT_OWN]
                   : mem_rdata_in[`PDH_BIT_OWN]) begin
              req_ff   <= 1'b1;
              maddr_ff <= cur_ff + buf_off;
            end
          end
        end
        S_BUF: begin
          if (mem_ack_in) begin
            // tx pointer taken as is, any byte alignment
            buf_ff <= mem_rdata_in;
            fv_ff  <= 1'b1;
          end
        end
        S_XFER: begin
          if (frag_done_in) begin
            fv_ff    <= 1'b0;
            req_ff   <= 1'b1;
            mwr_ff   <= 1'b1;
            maddr_ff <= cur_ff + `PDH_OFF_CMD;
            if (rx) begin
              // rx: hand to driver, fcs always in the buffer
              wb_ff[`PDH_BIT_OWN]  <= 1'b1;
              wb_ff[`PDH_BIT_MORE] <= ~frag_last_in;
              wb_ff[`PDH_BIT_FCS]  <= 1'b1;
              wb_ff[`PDH_SZ_HI:`PDH_SZ_LO] <= frag_size_in;
              wb_ff[`PDH_RSV_HI:`PDH_RSV_LO] <= 4'h0;
            end else begin
              // tx: give back, keep driver's count and fcs choice
              wb_ff[`PDH_BIT_OWN]  <= 1'b0;
              wb_ff[`PDH_BIT_MORE] <= more;
              wb_ff[`PDH_BIT_FCS]  <= cmd_ff[`PDH_BIT_FCS];
              wb_ff[`PDH_SZ_HI:`PDH_SZ_LO] <=
                cmd_ff[`PDH_SZ_HI:`PDH_SZ_LO];
              wb_ff[`PDH_RSV_HI:`PDH_RSV_LO] <=
                cmd_ff[`PDH_RSV_HI:`PDH_RSV_LO];
            end
            wb_ff[`PDH_BIT_DESCRIPTOR_INTERRUPT_REQUEST] <= descriptor_interrupt_request;
            // completion only in the last descriptor of a packet
            wb_ff[`PDH_BIT_OK]   <= last & frag_ok_in;
            // status field meaning follows the direction bit
            wb_ff[`PDH_ST_HI:`PDH_ST_LO] <= last ? frag_status_in
                                               : {SW{1'b0}};
          end
        end
        S_WB: begin
          if (mem_ack_in) begin
            mwr_ff <= 1'b0;
            cur_ff <= link_ff;
            if (en) begin
              req_ff   <= 1'b1;
              maddr_ff <= link_ff + `PDH_OFF_LINK;
            end
          end
        end
        default: begin
          fv_ff  <= 1'b0;
          req_ff <= 1'b0;
        end
      endcase
    end
  end

  // control, poll request, events and enables
  always @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      ctrl_ff <= 4'h0;
      poll_ff <= 1'b0;
      stat_ff <= {`PDH_EV_W{1'b0}};
      ien_ff  <= {`PDH_EV_W{1'b0}};
    end else begin
      if (wr && dpa_ff == `PDH_REG_CTRL) begin
        ctrl_ff <= {1'b0, hwdata_in[2:0]};
      end
      // poll set wins over the clear taken when a fetch starts
      if (wr && dpa_ff == `PDH_REG_CTRL && hwdata_in[`PDH_CTL_POLL]) begin
        poll_ff <= 1'b1;
      end else if (state_ff == S_IDLE && en) begin
        poll_ff <= 1'b0;
      end
      if (wr && dpa_ff == `PDH_REG_IEN) begin
        ien_ff <= hwdata_in[`PDH_EV_W-1:0];
      end
      // write-one-to-clear; a new event in the same cycle survives
      if (wr && dpa_ff == `PDH_REG_ICLR) begin
        stat_ff <= (stat_ff & ~hwdata_in[`PDH_EV_W-1:0]) | ev;
      end else begin
        stat_ff <= stat_ff | ev;
      end
    end
  end

  // register read mux, sampled in the address phase
  // limitation: a read straight behind a write to the same register
  // returns the old value, as the write lands at the end of its data
  // phase; software leaves one idle cycle between them
  reg [31:0] rmux;
  always @* begin
    case (haddr_in[7:0])
      `PDH_REG_CTRL:  rmux = {28'h0000000, 1'b0, ctrl_ff[2:0]};
      `PDH_REG_DESC:  rmux = cur_ff;
      `PDH_REG_STAT:  rmux = {29'h00000000, stat_ff};
      `PDH_REG_IEN:   rmux = {29'h00000000, ien_ff};
      `PDH_REG_STATE: rmux = {23'h000000, poll_ff, state_ff};
      default:        rmux = 32'h0000_0000; // unmapped and clear reg
    endcase
  end

  // ahb-lite slave: zero wait states, data phase follows address phase
  always @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      dp_ff    <= 1'b0;
      dpw_ff   <= 1'b0;
      dpa_ff   <= 8'h00;
      rdata_ff <= 32'h0000_0000;
    end else if (hready_in) begin
      dp_ff  <= acc;
      dpw_ff <= hwrite_in;
      dpa_ff <= haddr_in[7:0];
      if (acc && !hwrite_in) begin
        rdata_ff <= rmux;
      end
    end
  end

  assign hrdata_out     = rdata_ff;
  assign hreadyout_out  = 1'b1;
  assign hresp_out      = 1'b0;

  assign mem_req_out    = req_ff;
  assign mem_write_out  = mwr_ff;
  assign mem_addr_out   = maddr_ff;
  assign mem_wdata_out  = wb_ff;

  assign frag_valid_out = fv_ff;
  assign frag_addr_out  = buf_ff;
  assign frag_size_out  = cmd_ff[`PDH_SZ_HI:`PDH_SZ_LO];
  assign frag_last_out  = ~more;
  assign frag_rx_out    = rx;
  // only meaningful on tx; rx descriptors never suppress
  assign suppress_fcs_append_out = ~rx & cmd_ff[`PDH_BIT_FCS];

  assign irq_out = |(stat_ff & ien_ff);

endmodule
`default_nettype wire

/* File: dv/pdh_props.sv */
// checker: port-level properties of the descriptor handler
// assumes a bind onto pdh_descriptor_handler, one clock domain
`timescale 1ns/1ps
`default_nettype none
module pdh_props (
  input wire logic        ref_clk_in,
  input wire logic        reset_n_in,
  input wire logic        mem_req_out,
  input wire logic        mem_write_out,
  input wire logic [31:0] mem_addr_out,
  input wire logic [31:0] mem_wdata_out,
  input wire logic        mem_ack_in,
  input wire logic        frag_valid_out,
  input wire logic [31:0] frag_addr_out,
  input wire logic        frag_rx_out,
  input wire logic        suppress_fcs_append_out,
  input wire logic        frag_done_in
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  // write-back word on the memory port
  wire wb_on = mem_req_out && mem_write_out;
  a_mem_hold: assert property (
    mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out)
    && $stable(mem_wdata_out)) else $error("memory request not held");
  a_word_align: assert property (
    mem_req_out |-> mem_addr_out[1:0] == 2'b00)
    else $error("descriptor word not aligned");
  a_tx_release: assert property (
    wb_on && !frag_rx_out |-> !mem_wdata_out[31])
    else $error("tx write-back keeps ownership");
  a_rx_handover: assert property (
    wb_on && frag_rx_out |-> mem_wdata_out[31] && mem_wdata_out[28])
    else $error("rx write-back flags wrong");
  a_rx_reserved: assert property (
    wb_on && frag_rx_out |-> mem_wdata_out[15:12] == 4'h0)
    else $error("rx reserved bits set");
  a_ok_last: assert property (
    wb_on && mem_wdata_out[30] |-> !mem_wdata_out[27]
    && mem_wdata_out[26:16] == 11'h0) else $error("status in middle");
  a_frag_hold: assert property (
    frag_valid_out && !frag_done_in |=> frag_valid_out
    && $stable(frag_addr_out)) else $error("fragment offer dropped");
  a_frag_end: assert property (
    frag_valid_out && frag_done_in |=> !frag_valid_out)
    else $error("fragment offered twice");
  a_rx_nosup: assert property (
    frag_rx_out |-> !suppress_fcs_append_out)
    else $error("fcs suppress in rx");
endmodule
bind pdh_descriptor_handler pdh_props pdh_props_inst (.ref_clk_in,
  .reset_n_in, .mem_req_out, .mem_write_out, .mem_addr_out,
  .mem_wdata_out, .mem_ack_in, .frag_valid_out, .frag_addr_out,
  .frag_rx_out, .suppress_fcs_append_out, .frag_done_in);
`default_nettype wire

/* File: dv/pdh_mem_model.sv */
// host memory behind the bus master port, 256 words
// assumes requests held until ack; answers after 0..3 cycles
`timescale 1ns/1ps
`default_nettype none
module pdh_mem_model (
  input  wire logic        ref_clk_in,
  input  wire logic        req_in,
  input  wire logic        write_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [31:0] wdata_in,
  output var  logic        ack_out,
  output var  logic [31:0] rdata_out
);
  logic [31:0] mem_ff [0:255]; // descriptor words, filled by the bench
  logic [1:0]  wait_ff;        // random stall before the answer
  initial begin
    ack_out = 1'b0;
    rdata_out = 32'h0;
    wait_ff = 2'h0;
  end
  // one-cycle ack; idle data toggles so stale reads never match
  always @(posedge ref_clk_in) begin
    ack_out <= 1'b0;
    rdata_out <= ~rdata_out;
    if (req_in && !ack_out) begin
      if (wait_ff != 2'h0) begin
        wait_ff <= wait_ff - 2'h1;
      end else begin
        ack_out <= 1'b1;
        wait_ff <= 2'($urandom_range(3));
        if (write_in) mem_ff[addr_in[9:2]] <= wdata_in;
        else rdata_out <= mem_ff[addr_in[9:2]];
      end
    end
  end
endmodule
`default_nettype wire

/* File: dv/packet_descriptor_handler_tb.sv */
// bench: tx chain, ownership stall, refetch, rx legacy layout
// assumes the handler, its checker and the memory model
`timescale 1ns/1ps
`default_nettype none
module packet_descriptor_handler_tb;
  logic        ref_clk_in, reset_n_in, hsel_in, hwrite_in, hreadyout_out;
  logic        hresp_out, mem_req_out, mem_write_out, mem_ack_in;
  logic        frag_valid_out, frag_last_out, frag_rx_out, irq_out;
  logic        suppress_fcs_append_out, frag_done_in, frag_last_in;
  logic        frag_ok_in, rx_mode, last_rx;
  logic [1:0]  htrans_in;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, mem_addr_out, rdat;
  logic [31:0] mem_wdata_out, mem_rdata_in, frag_addr_out;
  logic [11:0] frag_size_out, frag_size_in;
  logic [10:0] frag_status_in;
  logic [63:0] frag_q[$], wb_q[$]; // expected fragments, write-backs
  int          n_fail, checks_done;
  pdh_descriptor_handler pdh_descriptor_handler_inst (.ref_clk_in,
    .reset_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
    .hsize_in(3'h2), .hwdata_in, .hready_in(hreadyout_out), .hrdata_out,
    .hreadyout_out, .hresp_out, .mem_req_out, .mem_write_out,
    .mem_addr_out, .mem_wdata_out, .mem_ack_in, .mem_rdata_in,
    .frag_valid_out, .frag_addr_out, .frag_size_out, .frag_last_out,
    .frag_rx_out, .suppress_fcs_append_out, .frag_done_in, .frag_size_in,
    .frag_last_in, .frag_ok_in, .frag_status_in, .irq_out);
  pdh_mem_model pdh_mem_model_inst (.ref_clk_in, .req_in(mem_req_out),
    .write_in(mem_write_out), .addr_in(mem_addr_out),
    .wdata_in(mem_wdata_out), .ack_out(mem_ack_in),
    .rdata_out(mem_rdata_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  task print_verdict;
    if (n_fail == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // single ahb-lite word transfer, waits on hready in both phases
  task ahb(input logic w, input logic [31:0] a, d);
    @(posedge ref_clk_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    hwrite_in <= w;
    haddr_in <= a;
    @(posedge ref_clk_in);
    while (!hreadyout_out) @(posedge ref_clk_in);
    htrans_in <= 2'h0;
    hwdata_in <= d;
    @(posedge ref_clk_in);
    while (!hreadyout_out) @(posedge ref_clk_in);
    rdat = hrdata_out;
  endtask
  task rd(input logic [31:0] a, e);
    ahb(1'b0, a, 32'h0);
    chk(rdat, e);
    chk(hresp_out, 1'b0);
  endtask
  // host builds a descriptor; legacy puts junk in the ignored count
  task desc(input logic [31:0] at, lk, cmd, b, input logic leg);
    pdh_mem_model_inst.mem_ff[at[9:2]] = lk;
    pdh_mem_model_inst.mem_ff[at[9:2]+1] = cmd;
    pdh_mem_model_inst.mem_ff[at[9:2]+2] = leg ? 32'hFFFF_FFFF : b;
    pdh_mem_model_inst.mem_ff[at[9:2]+3] = b;
  endtask
  // poll status until the engine reports an ownership stall
  task run(input logic [31:0] ctl);
    ahb(1'b1, 32'h0, ctl);
    rdat = 32'h0;
    for (int i = 0; i < 300 && !rdat[1]; i++) ahb(1'b0, 32'h8, 32'h0);
  endtask
  // mac stand-in: checks the offer, answers after a random stall
  initial forever begin
    logic [63:0] nt;
    logic [31:0] cmd;
    logic        lst;
    @(posedge ref_clk_in);
    if (frag_valid_out) begin
      nt = frag_q.pop_front();
      cmd = pdh_mem_model_inst.mem_ff[nt[41:34]+1];
      chk(frag_addr_out, nt[31:0]);
      chk({frag_rx_out, frag_last_out, suppress_fcs_append_out,
        frag_size_out}, {rx_mode, ~cmd[30], cmd[28] & ~rx_mode,
        cmd[11:0]});
      repeat ($urandom_range(3)) @(posedge ref_clk_in);
      lst = rx_mode ? 1'($urandom) : ~cmd[30];
      last_rx = lst;
      frag_done_in <= 1'b1;
      frag_last_in <= lst;
      frag_ok_in <= 1'($urandom);
      frag_status_in <= 11'($urandom);
      frag_size_in <= 12'($urandom);
      #1;
      wb_q.push_back({nt[63:32] + 32'h4, rx_mode ?
        {2'b10 | {1'b0, ~lst}, cmd[29], 1'b1, lst & frag_ok_in,
        lst ? frag_status_in : 11'h0, 4'h0, frag_size_in} :
        {1'b0, cmd[30:28], lst & frag_ok_in,
        lst ? frag_status_in : 11'h0, cmd[15:0]}});
      @(posedge ref_clk_in);
      frag_done_in <= 1'b0;
    end
  end
  // write-back monitor compares against the oldest note
  always @(posedge ref_clk_in) begin
    logic [63:0] nt;
    if (mem_req_out && mem_write_out && mem_ack_in) begin
      nt = wb_q.pop_front();
      chk(mem_addr_out, nt[63:32]);
      chk(mem_wdata_out, nt[31:0]);
    end
  end
  initial begin
    #(25 * 40000);
    n_fail++;
    print_verdict;
  end
  initial begin
    void'($urandom(95));
    {reset_n_in, hsel_in, hwrite_in, htrans_in, haddr_in} = '0;
    {hwdata_in, frag_done_in, frag_last_in, frag_ok_in} = '0;
    {frag_size_in, frag_status_in, rx_mode, n_fail, checks_done} = '0;
    repeat (3) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    rd(32'h0, 32'h0);
    ahb(1'b1, 32'hC, 32'h7);
    rd(32'hC, 32'h7);
    ahb(1'b1, 32'h18, 32'hFFFF_FFFF);
    rd(32'h18, 32'h0);
    ahb(1'b1, 32'h4, 32'h43);
    rd(32'h4, 32'h40);
    // tx: two-descriptor packet then an unowned descriptor
    desc(32'h40, 32'h80, 32'hE000_0005, 32'h103, 1'b0);
    desc(32'h80, 32'hC0, 32'h9000_003C, 32'h201, 1'b0);
    desc(32'hC0, 32'h40, 32'h0000_0001, 32'h300, 1'b0);
    frag_q = '{{32'h40, 32'h103}, {32'h80, 32'h201}};
    run(32'h9);
    rd(32'h8, 32'h7);
    rd(32'h14, 32'h1);
    chk(irq_out, 1'b1);
    ahb(1'b1, 32'h10, 32'h7);
    rd(32'h8, 32'h0);
    chk(irq_out, 1'b0);
    // hand the stalled descriptor over and poll again: refetch
    pdh_mem_model_inst.mem_ff[49] = 32'h8000_0001;
    frag_q.push_back({32'hC0, 32'h300});
    run(32'h9);
    rd(32'h8, 32'h6);
    ahb(1'b1, 32'h10, 32'h7);
    // rx in legacy layout; word-aligned buffer from the host
    rx_mode = 1'b1;
    desc(32'h100, 32'h140, 32'h2000_0000, 32'h400, 1'b1);
    desc(32'h140, 32'h100, 32'h8000_0000, 32'h500, 1'b1);
    frag_q.push_back({32'h100, 32'h400});
    ahb(1'b1, 32'h4, 32'h100);
    run(32'hF);
    rd(32'h8, {29'h0, last_rx, 2'b11});
    ahb(1'b1, 32'hC, 32'h0);
    repeat (2) @(posedge ref_clk_in);
    chk(irq_out, 1'b0);
    ahb(1'b1, 32'hC, 32'h1);
    repeat (2) @(posedge ref_clk_in);
    chk(irq_out, 1'b1);
    // every noted fragment and write-back must have been seen
    chk(frag_q.size() + wb_q.size(), 0);
    print_verdict;
  end
endmodule
`default_nettype wire
